//--- logic/brf_regs.svh
// opcodes, index limit and pointer field codes for the instruction execute block
`ifndef BRF_REGS_SVH
`define BRF_REGS_SVH
`define BRF_OP_BRANCH 4'hD
`define BRF_OP_BITSET 4'h8
`define BRF_OP_ROT 6'h10
`define BRF_OP_COMP 6'h07
`define BRF_OP_CPSEQ 7'h31
`define BRF_OP_SET_FILE_ONES 7'h34
`define BRF_OP_PTRSUB 8'hE9
`define BRF_IDX_LIMIT 8'h5F
`define BRF_PTR_RET 2'h3
`define BRF_PTR_RET_SEL 2'h2
`endif

//--- logic/brf_pkg.sv
// types shared by the instruction execute block
package brf_pkg;
  typedef struct packed {
    logic [20:0] pc;
    logic [7:0] wreg;
    logic [7:0] fdata;
    logic [3:0] bank;
    logic [11:0] ptr0;
    logic [11:0] ptr1;
    logic [11:0] ptr2;
    logic [20:0] stack_top;
  } brf_core_state_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
    logic wr;
  } brf_file_acc_t;
endpackage

//--- logic/brf_ptr_sub.sv
// one pointer register with literal subtract
`timescale 1ns/1ps
module brf_ptr_sub
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // subtract request
  input wire logic sub_in,
  input wire logic [5:0] lit_in,
  // value
  output logic [11:0] ptr_out
);
  logic [11:0] ptr_d;
  // literal is unsigned, zero extended
  always_comb
  begin
    ptr_d = ptr_out;
    if (sub_in)
      ptr_d = ptr_out - {6'h00, lit_in};
  end
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      ptr_out <= 12'h000;
    else
      ptr_out <= ptr_d;
  end
endmodule

//--- logic/brf_exec.sv
// execute stage for branch, bit, rotate and pointer-subtract instructions
`timescale 1ns/1ps
`include "brf_regs.svh"
// Summary of operation
// - relative branch target is incremented pc plus twice signed 11-bit offset.
// - relative branch takes two cycles, second is a no-operation.
// - access bit zero picks access bank, one uses bank select register.
// - access bit zero, extended set, address up to 5Fh is indexed.
// - destination bit zero writes accumulator, one writes file register; bit set and set-file-ones always write file register.
// - rotate right without carry; only negative and zero flags change.
// - subtract 6-bit literal from chosen pointer, no flags, one cycle.
// - pointer field 11 subtracts from pointer 2 then returns from stack.
// - subtract-and-return takes two cycles, second is a no-operation.
module brf_exec
  import brf_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // instruction stream, one word per cycle
  input wire logic [15:0] instr_in,
  input wire logic next_two_word_in,
  input wire logic ext_set_in,
  // core context
  input wire logic [20:0] pc_in,
  input wire logic [7:0] wreg_in,
  input wire logic [3:0] bank_select_reg_in,
  input wire logic [20:0] return_stack_top_in,
  input wire logic [7:0] fdata_in,
  // results
  output logic pc_load_out,
  output logic [20:0] pc_next_out,
  output logic pop_out,
  output logic flush_out,
  output brf_file_acc_t file_out,
  output logic wreg_wr_out,
  output logic [7:0] wreg_out,
  output logic [1:0] nz_wr_out,
  output logic [1:0] nz_out,
  output logic [11:0] ptr0_out,
  output logic [11:0] ptr1_out,
  output logic [11:0] ptr2_out
);
  // ************************************************************
  // cycle control
  // ************************************************************
  typedef enum logic [1:0] {EXEC, NOP1, NOP2} brf_state_t;
  brf_state_t state_q, state_d;
  logic idle;
  logic [15:0] op;
  logic [7:0] f;
  logic [11:0] addr;
  logic is_bra, is_bsf, is_rot, is_com, is_cps, is_set_file_ones, is_ptr, is_ret;
  logic [7:0] res;
  logic res_valid, dest_w;
  logic [2:0] psub;
  logic [5:0] lit;
  logic [20:0] target;
  logic pc_load_d, pop_d, flush_d, wwr_d, fwr_d;
  logic [1:0] nzw_d, nz_d;
  logic [20:0] pcn_d;
  logic [7:0] wreg_d;
  brf_file_acc_t file_d;

  assign idle = (state_q == EXEC);
  // the prefetched word is ignored during nop cycles
  assign op = idle ? instr_in : 16'h0000;
  assign f = op[7:0];
  assign lit = op[5:0];
  assign is_bra = idle && (op[15:12] == `BRF_OP_BRANCH) && !op[11];
  assign is_bsf = idle && (op[15:12] == `BRF_OP_BITSET);
  assign is_rot = idle && (op[15:10] == `BRF_OP_ROT);
  assign is_com = idle && (op[15:10] == `BRF_OP_COMP);
  assign is_cps = idle && (op[15:9] == `BRF_OP_CPSEQ);
  assign is_set_file_ones = idle && (op[15:9] == `BRF_OP_SET_FILE_ONES);
  assign is_ptr = idle && (op[15:8] == `BRF_OP_PTRSUB);
  assign is_ret = is_ptr && (op[7:6] == `BRF_PTR_RET);
  assign dest_w = !op[9];

  // ************************************************************
  // operand address and data path
  // ************************************************************
  always_comb
  begin
    if (op[8])
      addr = {bank_select_reg_in, f};
    else if (ext_set_in && (f <= `BRF_IDX_LIMIT))
      addr = ptr2_out + {4'h0, f};
    else
      addr = (f[7]) ? {4'hF, f} : {4'h0, f};
  end

  assign target = pc_in + {{9{op[10]}}, op[10:0], 1'b0};

  always_comb
  begin
    res = fdata_in;
    res_valid = 1'b0;
    nzw_d = 2'b00;
    if (is_bsf)
    begin
      res = fdata_in | (8'h01 << op[11:9]);
      res_valid = 1'b1;
    end
    else if (is_rot)
    begin
      res = {fdata_in[0], fdata_in[7:1]};
      res_valid = 1'b1;
      nzw_d = 2'b11;
    end
    else if (is_com)
    begin
      res = ~fdata_in;
      res_valid = 1'b1;
      nzw_d = 2'b11;
    end
    else if (is_set_file_ones)
    begin
      res = 8'hFF;
      res_valid = 1'b1;
    end
    nz_d = {res[7], (res == 8'h00)};
  end

  // ************************************************************
  // next-state and result registers
  // ************************************************************
  always_comb
  begin
    state_d = EXEC;
    pc_load_d = 1'b0;
    pcn_d = pc_next_out;
    pop_d = 1'b0;
    flush_d = 1'b0;
    wwr_d = res_valid && dest_w && !is_bsf && !is_set_file_ones;
    fwr_d = res_valid && !wwr_d;
    wreg_d = wwr_d ? res : wreg_out;
    file_d = '{addr: addr, data: res, wr: fwr_d};
    unique case (state_q)
      EXEC:
      begin
        if (is_bra)
        begin
          pc_load_d = 1'b1;
          pcn_d = target;
          flush_d = 1'b1;
          state_d = NOP1;
        end
        else if (is_ret)
        begin
          pc_load_d = 1'b1;
          pcn_d = return_stack_top_in;
          pop_d = 1'b1;
          flush_d = 1'b1;
          state_d = NOP1;
        end
        else if (is_cps && (fdata_in == wreg_in))
        begin
          flush_d = 1'b1;
          state_d = next_two_word_in ? NOP2 : NOP1;
        end
      end
      NOP2:
        state_d = NOP1;
      NOP1:
        state_d = EXEC;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= EXEC;
      pc_load_out <= 1'b0;
      pc_next_out <= 21'h000000;
      pop_out <= 1'b0;
      flush_out <= 1'b0;
      file_out <= '0;
      wreg_wr_out <= 1'b0;
      wreg_out <= 8'h00;
      nz_wr_out <= 2'b00;
      nz_out <= 2'b00;
    end
    else
    begin
      state_q <= state_d;
      pc_load_out <= pc_load_d;
      pc_next_out <= pcn_d;
      pop_out <= pop_d;
      flush_out <= flush_d;
      file_out <= file_d;
      wreg_wr_out <= wwr_d;
      wreg_out <= wreg_d;
      nz_wr_out <= nzw_d;
      nz_out <= nz_d;
    end
  end

  // ************************************************************
  // pointer registers
  // ************************************************************
  // pointer subtract, field 3 maps to pointer 2
  assign psub[0] = is_ptr && (op[7:6] == 2'h0);
  assign psub[1] = is_ptr && (op[7:6] == 2'h1);
  assign psub[2] = is_ptr && ((op[7:6] == `BRF_PTR_RET_SEL) || is_ret);

  brf_ptr_sub u_ptr0 (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sub_in(psub[0]), .lit_in(lit), .ptr_out(ptr0_out));
  brf_ptr_sub u_ptr1 (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sub_in(psub[1]), .lit_in(lit), .ptr_out(ptr1_out));
  brf_ptr_sub u_ptr2 (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sub_in(psub[2]), .lit_in(lit), .ptr_out(ptr2_out));
endmodule

//--- sim/brf_exec_assertions.sv
// concurrent checks on the ports of the instruction execute block
`timescale 1ns/1ps
module brf_exec_assertions
  import brf_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // inputs
  input wire logic [15:0] instr_in,
  input wire logic [20:0] pc_in,
  input wire logic [7:0] wreg_in,
  input wire logic [3:0] bank_select_reg_in,
  input wire logic [20:0] return_stack_top_in,
  input wire logic [7:0] fdata_in,
  // results
  input wire logic pc_load_out,
  input wire logic [20:0] pc_next_out,
  input wire logic pop_out,
  input wire logic flush_out,
  input wire brf_file_acc_t file_out,
  input wire logic wreg_wr_out,
  input wire logic [7:0] wreg_out,
  input wire logic [1:0] nz_wr_out,
  input wire logic [11:0] ptr0_out,
  input wire logic [11:0] ptr2_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // a word sampled while flush stands is dropped, so it must not arm a check
  wire logic live = !flush_out;
  a_branch_target: assert property (
    live && instr_in[15:11] == 5'h1A |=> pc_load_out && pc_next_out ==
    $past(pc_in) + {{9{$past(instr_in[10])}}, $past(instr_in[10:0]), 1'b0}) else $error("bad branch");
  a_flush_idle: assert property (
    flush_out |=> !pc_load_out && !file_out.wr && !wreg_wr_out && nz_wr_out == 2'h0) else $error("busy nop");
  a_bit_set: assert property (
    live && instr_in[15:12] == 4'h8 |=> file_out.wr && nz_wr_out == 2'h0 &&
    file_out.data == ($past(fdata_in) | (8'h01 << $past(instr_in[11:9])))) else $error("bad bit set");
  a_bank_select: assert property (
    live && instr_in[15:12] == 4'h8 && instr_in[8] |=>
    file_out.addr == {$past(bank_select_reg_in), $past(instr_in[7:0])}) else $error("bad bank");
  a_rotate_dest: assert property (
    live && instr_in[15:10] == 6'h10 |=> nz_wr_out == 2'h3 && file_out.wr == $past(instr_in[9]) &&
    wreg_wr_out != file_out.wr && (file_out.wr ? file_out.data : wreg_out) ==
    {$past(fdata_in[0]), $past(fdata_in[7:1])}) else $error("bad rotate");
  a_ptr_sub: assert property (
    live && instr_in[15:6] == 10'h3A4 |=> !pc_load_out && nz_wr_out == 2'h0 &&
    ptr0_out == $past(ptr0_out) - {6'h0, $past(instr_in[5:0])}) else $error("bad pointer");
  a_ptr_return: assert property (
    live && instr_in[15:6] == 10'h3A7 |=> pop_out && pc_load_out && pc_next_out == $past(return_stack_top_in)
    && ptr2_out == $past(ptr2_out) - {6'h0, $past(instr_in[5:0])}) else $error("bad return");
  a_skip_equal: assert property (
    live && instr_in[15:9] == 7'h31 |=> !pc_load_out &&
    flush_out == ($past(fdata_in) == $past(wreg_in))) else $error("bad skip");
endmodule

//--- sim/brf_exec_tb.sv
// self-checking bench for the instruction execute block
`timescale 1ns/1ps
module brf_exec_tb;
  import brf_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, next_two_word_in = 1'b0, ext_set_in = 1'b0;
  logic [15:0] instr_in = 16'h0000;
  logic [20:0] pc_in = 21'h0, return_stack_top_in = 21'h0, pc_next_out;
  logic [7:0] wreg_in = 8'h00, fdata_in = 8'h00, wreg_out;
  logic [3:0] bank_select_reg_in = 4'h0;
  logic pc_load_out, pop_out, flush_out, wreg_wr_out;
  logic [1:0] nz_wr_out, nz_out;
  logic [11:0] ptr0_out, ptr1_out, ptr2_out;
  brf_file_acc_t file_out;
  int fail_count = 0, checks = 0, cycles = 0;
  int ptr[3] = '{0, 0, 0};
  // opcode base in the upper half, randomised field mask in the lower half
  // pointer subtracts run first, so that indexed addressing later meets a non-zero pointer 2
  logic [31:0] kinds[$] = '{32'hE90000FF, 32'hD00007FF, 32'h80000FFF, 32'h400003FF, 32'h1C0003FF,
    32'h620001FF, 32'h680001FF};
  brf_exec i_dut (.clk_in, .sys_rst_in, .instr_in, .next_two_word_in, .ext_set_in, .pc_in, .wreg_in,
    .bank_select_reg_in, .return_stack_top_in, .fdata_in, .pc_load_out, .pc_next_out, .pop_out, .flush_out,
    .file_out, .wreg_wr_out, .wreg_out, .nz_wr_out, .nz_out, .ptr0_out, .ptr1_out, .ptr2_out);
  always #4 clk_in = ~clk_in;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // under two hundred cycles are expected, so this limit only trips on a hang
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // present one word, then a banked bit set that a nop cycle swallows after a branch, return or taken skip
  task automatic run(input logic [15:0] ins);
    logic [7:0] f;
    logic [11:0] a;
    int p;
    f = 8'($urandom);
    @(posedge clk_in);
    instr_in <= ins;
    fdata_in <= f;
    wreg_in <= ins[0] ? f : 8'($urandom);
    {pc_in, bank_select_reg_in, ext_set_in, next_two_word_in} <= 27'($urandom);
    return_stack_top_in <= 21'($urandom);
    @(posedge clk_in);
    instr_in <= {8'h8F, 8'($urandom)};
    #1;
    f = ins[14] ? {fdata_in[0], fdata_in[7:1]} : ~fdata_in;
    a = ins[8] ? {bank_select_reg_in, ins[7:0]} : (ext_set_in && ins[7:0] <= 8'h5F) ?
      12'(ptr[2] + ins[7:0]) : {{4{ins[7]}}, ins[7:0]};
    p = ins[7:6] == 2'h3 ? 2 : ins[7:6];
    case (ins[15:12])
      4'hD: chk("branch", {pc_load_out, flush_out, pc_next_out}, {2'h3, pc_in + {{9{ins[10]}}, ins[10:0], 1'b0}});
      4'h8: chk("bitset", {file_out.wr, file_out.addr, file_out.data}, {1'b1, a, fdata_in | (8'h01 << ins[11:9])});
      4'h4, 4'h1: chk("result", {file_out.wr, wreg_wr_out, nz_wr_out, ins[9] ? file_out.data : wreg_out, nz_out},
        {ins[9], !ins[9], 2'h3, f, f[7], f == 8'h00});
      4'h6: if (ins[11])
        chk("set_file_ones", {file_out.wr, nz_wr_out, file_out.addr, file_out.data}, {1'b1, 2'h0, a, 8'hFF});
      else
        chk("skip", {flush_out, pc_load_out}, {fdata_in == wreg_in, 1'b0});
      default:
      begin
        ptr[p] = (ptr[p] - ins[5:0]) & 32'hFFF;
        chk("ptr", {pop_out, ptr0_out, ptr1_out, ptr2_out}, {p == 2 && ins[6], 12'(ptr[0]), 12'(ptr[1]), 12'(ptr[2])});
        if (ins[7:6] == 2'h3)
          chk("return", pc_next_out, return_stack_top_in);
      end
    endcase
    // a skip over a two-word instruction swallows one more word; the model decides, not the design
    if (ins[15:9] == 7'h31 && fdata_in == wreg_in && next_two_word_in)
    begin
      @(posedge clk_in);
      instr_in <= 16'h0000;
    end
  endtask
  initial
  begin
    void'($urandom(19811));
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    foreach (kinds[i])
    begin
      repeat (12) run(kinds[i][31:16] | (kinds[i][15:0] & 16'($urandom)));
      $display("test %0d done", i);
    end
    complete_run();
  end
endmodule
bind brf_exec brf_exec_assertions i_chk (.clk_in, .sys_rst_in, .instr_in, .pc_in, .wreg_in, .bank_select_reg_in,
  .return_stack_top_in, .fdata_in, .pc_load_out, .pc_next_out, .pop_out, .flush_out, .file_out, .wreg_wr_out,
  .wreg_out, .nz_wr_out, .ptr0_out, .ptr2_out);
